// >>> hdl/rsd_pkg.sv
// Purpose: Shared constants and types for the rail sleep and discharge register bank.
// Assumes: Registers are eight bits wide and reached by an eight-bit register address.
// Notes:   Reset values of the regulator three control register follow the default pattern.
package rsd_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] RSD_OFS_REG3_CTRL = 8'h29;
	localparam logic [7:0] RSD_OFS_DISCH_ONE = 8'h40;
	localparam logic [7:0] RSD_OFS_DISCH_TWO = 8'h41;
	localparam logic [7:0] RSD_OFS_DISCH_THREE = 8'h42;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int RSD_SLP_LSB = 4;
	localparam int RSD_DIS_BIT = 0;
	localparam int RSD_RSV_LSB = 1;
	localparam logic [1:0] RSD_SLP_NORMAL = 2'h0;
	localparam logic [1:0] RSD_SLP_ACTIVE = 2'h3;
	localparam logic [2:0] RSD_RSV_PATTERN = 3'h6;
	localparam logic [7:0] RSD_REG3_WMASK = 8'h3F;
	localparam logic [7:0] RSD_DISCH3_WMASK = 8'h3F;
	localparam logic [7:0] RSD_FULL_WMASK = 8'hFF;
	localparam logic [7:0] RSD_REG3_RESET = 8'h0C;
	localparam logic [7:0] RSD_ZERO_BYTE = 8'h00;
	localparam int RSD_NUM_RAILS = 12;
	localparam int RSD_NUM_FIELDS = 11;

	// ---------------------------------------------------------------
	// Discharge field encoding
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RSD_DISCH_NONE = 2'h0,
		RSD_DISCH_100R = 2'h1,
		RSD_DISCH_200R = 2'h2,
		RSD_DISCH_500R = 2'h3
	} rsd_disch_t;

	// Register access request from the serial management front end.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsd_req_t;

	// Discharge selection of eleven of the twelve rails, one field per rail.
	typedef struct packed {
		rsd_disch_t step_down_one;
		rsd_disch_t step_down_two;
		rsd_disch_t step_down_three;
		rsd_disch_t step_down_four;
		rsd_disch_t step_down_five;
		rsd_disch_t step_down_six;
		rsd_disch_t load_switch_a_one;
		rsd_disch_t linear_regulator_two;
		rsd_disch_t linear_regulator_three;
		rsd_disch_t load_switch_b_one;
		rsd_disch_t load_switch_b_two;
	} rsd_disch_set_t;

endpackage : rsd_pkg

// >>> hdl/rsd_regs.sv
// Purpose: Regulator three control and rail discharge control register bank.
// Assumes: A serial management front end presents one-cycle read and write strobes.
// Notes:   Rail enables come from the sequencer; sleep pins are raw pins and are synchronised.
//
// Summary of operation
// - Sleep select 00 keeps regulator three on its normal voltage regardless of pins.
// - Sleep select 11 uses sleep voltage while the assigned sleep pin is low.
// - Soft disable bit 0 low turns regulator three off regardless of enable pins.
// - Each discharge field clears to 00 while its rail is enabled.
// - Discharge codes: 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// - Third register: switch b two, b one, linear three; bits 7:6 read only.
`timescale 1ns/1ps
module rsd_regs (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Register access
	input wire rsd_pkg::rsd_req_t i_req,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// Regulator three control pins and sleep pin assignment
	input wire logic i_reg_three_pin_enable,
	input wire logic i_sleep_pin_first,
	input wire logic i_sleep_pin_second,
	input wire logic i_sleep_use_second,
	// Rail enable status from the sequencer, same clock
	input wire rsd_pkg::rsd_disch_set_t i_rail_enabled,
	// Regulator three outputs
	output logic o_reg_three_enable,
	output logic o_reg_three_use_sleep_voltage,
	// Discharge selections
	output rsd_pkg::rsd_disch_set_t o_discharge_select_field
);
	import rsd_pkg::*;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [1:0] reg_three_sleep_select_q;
	logic [2:0] reg_three_rsv_q;
	logic reg_three_soft_disable_q;
	logic [1:0] disch_q [RSD_NUM_FIELDS];
	logic [1:0] disch_d [RSD_NUM_FIELDS];
	logic [1:0] rail_en [RSD_NUM_FIELDS];
	logic [3:0] pins_sync;
	logic sleep_pin_lvl;
	logic [7:0] disch_one_rd;
	logic [7:0] disch_two_rd;
	logic [7:0] disch_three_rd;
	logic [7:0] rdata_d;

	// Field index order within the packed set, high field first.
	function automatic logic [1:0] field_of(input rsd_disch_set_t s, input int idx);
		logic [21:0] flat;
		flat = s;
		return flat[2*(RSD_NUM_FIELDS-1-idx) +: 2];
	endfunction : field_of

	function automatic logic write_hit(input rsd_req_t r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction : write_hit

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	rsd_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_async({i_sleep_use_second, i_reg_three_pin_enable, i_sleep_pin_second, i_sleep_pin_first}),
		.o_sync(pins_sync)
	);

	// ---------------------------------------------------------------
	// Regulator three control register
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			reg_three_sleep_select_q <= RSD_REG3_RESET[RSD_SLP_LSB +: 2];
			reg_three_rsv_q <= RSD_REG3_RESET[RSD_RSV_LSB +: 3];
			reg_three_soft_disable_q <= RSD_REG3_RESET[RSD_DIS_BIT];
		end else if (write_hit(i_req, RSD_OFS_REG3_CTRL)) begin
			// Reserved codes 01 and 10 are stored as written; the host keeps clear of them.
			reg_three_sleep_select_q <= i_req.wdata[RSD_SLP_LSB +: 2];
			reg_three_rsv_q <= i_req.wdata[RSD_RSV_LSB +: 3];
			reg_three_soft_disable_q <= i_req.wdata[RSD_DIS_BIT];
		end
	end

	// Reserved sleep codes act as normal voltage, the safer of the two outcomes.
	// The pin select strap is synchronised with the pins, so a select change never pairs with stale levels.
	assign sleep_pin_lvl = pins_sync[3] ? pins_sync[1] : pins_sync[0];

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_three_enable <= 1'b0;
			o_reg_three_use_sleep_voltage <= 1'b0;
		end else begin
			o_reg_three_enable <= reg_three_soft_disable_q && pins_sync[2];
			if (reg_three_sleep_select_q == RSD_SLP_ACTIVE) begin
				o_reg_three_use_sleep_voltage <= !sleep_pin_lvl;
			end else begin
				o_reg_three_use_sleep_voltage <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Discharge fields
	// ---------------------------------------------------------------
	// Field i lives in register i/4 at bits 2*(i%4); the set order matches that packing.
	always_comb begin
		for (int i = 0; i < RSD_NUM_FIELDS; i++) begin
			rail_en[i] = field_of(i_rail_enabled, i);
			disch_d[i] = disch_q[i];
			if (write_hit(i_req, RSD_OFS_DISCH_ONE) && (i / 4 == 0)) begin
				disch_d[i] = i_req.wdata[2*(i%4) +: 2];
			end else if (write_hit(i_req, RSD_OFS_DISCH_TWO) && (i / 4 == 1)) begin
				disch_d[i] = i_req.wdata[2*(i%4) +: 2];
			end else if (write_hit(i_req, RSD_OFS_DISCH_THREE) && (i / 4 == 2)) begin
				disch_d[i] = i_req.wdata[2*(i%4) +: 2];
			end
			// Enabled rail wins over a write in the same cycle, so no discharge fights the rail.
			if (rail_en[i] != 2'h0) begin
				disch_d[i] = RSD_DISCH_NONE;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < RSD_NUM_FIELDS; i++) begin
				disch_q[i] <= RSD_DISCH_NONE;
			end
		end else begin
			for (int i = 0; i < RSD_NUM_FIELDS; i++) begin
				disch_q[i] <= disch_d[i];
			end
		end
	end

	assign o_discharge_select_field = rsd_disch_set_t'({disch_q[0], disch_q[1], disch_q[2], disch_q[3],
		disch_q[4], disch_q[5], disch_q[6], disch_q[7], disch_q[8], disch_q[9], disch_q[10]});

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	assign disch_one_rd = {disch_q[3], disch_q[2], disch_q[1], disch_q[0]};
	assign disch_two_rd = {disch_q[7], disch_q[6], disch_q[5], disch_q[4]};
	assign disch_three_rd = {2'h0, disch_q[10], disch_q[9], disch_q[8]} & RSD_DISCH3_WMASK;

	always_comb begin
		if (i_req.addr == RSD_OFS_REG3_CTRL) begin
			rdata_d = {2'h0, reg_three_sleep_select_q, reg_three_rsv_q, reg_three_soft_disable_q}
				& RSD_REG3_WMASK;
		end else if (i_req.addr == RSD_OFS_DISCH_ONE) begin
			rdata_d = disch_one_rd;
		end else if (i_req.addr == RSD_OFS_DISCH_TWO) begin
			rdata_d = disch_two_rd;
		end else if (i_req.addr == RSD_OFS_DISCH_THREE) begin
			rdata_d = disch_three_rd;
		end else begin
			rdata_d = RSD_ZERO_BYTE;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= RSD_ZERO_BYTE;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (i_req.rd) begin
				o_rdata <= rdata_d;
			end
		end
	end

endmodule : rsd_regs

// >>> hdl/rsd_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of pin levels.
// Assumes: Inputs are quasi-static levels from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module rsd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule : rsd_sync

// >>> verif/rsd_checker.sv
// Purpose: Port checker for the rail sleep and discharge register bank.
// Assumes: Pins reach the outputs three edges after they change.
// Notes: Helper flops mirror the regulator three sleep select and soft disable fields.
`timescale 1ns/1ps
module rsd_checker import rsd_pkg::*; (
	// Clock, reset and bus
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire rsd_pkg::rsd_req_t i_req,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	// Pins and rails
	input wire logic i_reg_three_pin_enable,
	input wire logic i_sleep_pin_first,
	input wire logic i_sleep_pin_second,
	input wire logic i_sleep_use_second,
	input wire rsd_pkg::rsd_disch_set_t i_rail_enabled,
	input wire logic o_reg_three_enable,
	input wire logic o_reg_three_use_sleep_voltage,
	input wire rsd_pkg::rsd_disch_set_t o_discharge_select_field
);
	logic [1:0] slp_q;
	logic dis_q;
	logic [2:0] age_q;
	logic [21:0] en_mask;
	rsd_disch_set_t f, p_q;
	wire pin_sel = i_sleep_use_second ? i_sleep_pin_second : i_sleep_pin_first;
	assign f = o_discharge_select_field;
	always_comb for (int k = 0; k < 11; k++) en_mask[2*k +: 2] = {2{|i_rail_enabled[2*k +: 2]}};
	always_ff @(posedge i_core_clk) p_q <= f;
	// The age count hides pin history that was captured during reset.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			slp_q <= 2'h0;
			dis_q <= 1'b0;
			age_q <= 3'h0;
		end else begin
			if (i_req.wr && i_req.addr == RSD_OFS_REG3_CTRL) begin
				slp_q <= i_req.wdata[5:4];
				dis_q <= i_req.wdata[0];
			end
			if (age_q != 3'h4) age_q <= age_q + 3'h1;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sleep_normal_a: assert property ($past(slp_q) != 2'h3 |-> !o_reg_three_use_sleep_voltage)
		else $error("sleep voltage in normal mode");
	sleep_pin_a: assert property (age_q == 3'h4 && $past(slp_q) == 2'h3 |->
		o_reg_three_use_sleep_voltage == !$past(pin_sel, 3)) else $error("sleep voltage not pin driven");
	soft_disable_a: assert property (age_q == 3'h4 |->
		o_reg_three_enable == ($past(dis_q) && $past(i_reg_three_pin_enable, 3))) else $error("bad enable");
	rail_clear_a: assert property (|en_mask |=> (f & $past(en_mask)) == '0)
		else $error("field not cleared");
	write_field_a: assert property (i_req.wr && i_req.addr == RSD_OFS_DISCH_ONE && !(|i_rail_enabled.step_down_one)
		|=> f.step_down_one == $past(i_req.wdata[1:0])) else $error("field not written");
	disch_one_a: assert property (i_req.rd && i_req.addr == RSD_OFS_DISCH_ONE |=> o_rvalid && o_rdata ==
		{p_q.step_down_four, p_q.step_down_three, p_q.step_down_two, p_q.step_down_one}) else $error("bad 0x40");
	disch_two_a: assert property (i_req.rd && i_req.addr == RSD_OFS_DISCH_TWO |=> o_rdata ==
		{p_q.linear_regulator_two, p_q.load_switch_a_one, p_q.step_down_six, p_q.step_down_five}) else $error("bad 0x41");
	disch_three_a: assert property (i_req.rd && i_req.addr == RSD_OFS_DISCH_THREE |=> o_rdata == {2'h0,
		p_q.load_switch_b_two, p_q.load_switch_b_one, p_q.linear_regulator_three}) else $error("bad 0x42");
	reserved_zero_a: assert property (i_req.rd && i_req.addr == RSD_OFS_REG3_CTRL |=>
		o_rdata[7:6] == 2'h0 && o_rdata[0] == $past(dis_q)) else $error("bad 0x29");
endmodule : rsd_checker
bind rsd_regs rsd_checker u_chk (.i_core_clk, .i_nrst, .i_req, .o_rdata, .o_rvalid, .i_reg_three_pin_enable,
	.i_sleep_pin_first, .i_sleep_pin_second, .i_sleep_use_second, .i_rail_enabled, .o_reg_three_enable,
	.o_reg_three_use_sleep_voltage, .o_discharge_select_field);

// >>> verif/rsd_host_model.sv
// Purpose: Host model issuing one-cycle register requests.
// Assumes: Read data is registered one edge after the request is taken.
// Notes: The control byte helper only ever writes legal sleep codes.
`timescale 1ns/1ps
module rsd_host_model import rsd_pkg::*; (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output rsd_pkg::rsd_req_t o_req
);
	initial o_req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_core_clk);
		o_req <= '0;
	endtask : wr
	// Read data and valid are taken at the edge where the valid pulse is sampled high.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge i_core_clk);
		o_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_core_clk);
		o_req <= '0;
		@(posedge i_core_clk);
		v = i_rvalid;
		d = i_rdata;
	endtask : rd
	task automatic set_reg_three(input logic sleep_on, input logic enable);
		wr(RSD_OFS_REG3_CTRL, {2'h0, {2{sleep_on}}, RSD_RSV_PATTERN, enable});
	endtask : set_reg_three
endmodule : rsd_host_model

// >>> verif/testbench.sv
// Purpose: Directed test of the rail sleep and discharge register bank.
// Assumes: Pin changes settle within five edges.
// Notes: Pin table entries are {sleep, enable, pins, expected}.
`timescale 1ns/1ps
module testbench;
	import rsd_pkg::*;
	logic i_core_clk, i_nrst, pin_en, slp1, slp2, use2, rvalid, reg_en, reg_slp, v;
	logic [7:0] rdata, d;
	rsd_disch_set_t rail, disch;
	rsd_req_t req;
	int miscompares = 0;
	int samples_checked = 0;
	localparam logic [7:0] pin_cases [7] = '{8'h69, 8'hEB, 8'hF9, 8'hED, 8'hE7, 8'hA6, 8'h44};
	rsd_regs uut (.i_core_clk, .i_nrst, .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .i_reg_three_pin_enable(pin_en),
		.i_sleep_pin_first(slp1), .i_sleep_pin_second(slp2), .i_sleep_use_second(use2), .i_rail_enabled(rail),
		.o_reg_three_enable(reg_en), .o_reg_three_use_sleep_voltage(reg_slp), .o_discharge_select_field(disch));
	rsd_host_model host (.i_core_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d, v);
		chk("read valid", 22'h1, {21'h0, v});
		chk("read data", {14'h0, e}, {14'h0, d});
	endtask : rd_chk
	task automatic pins(input logic [3:0] v);
		@(posedge i_core_clk);
		{pin_en, slp1, slp2, use2} <= v;
		repeat (5) @(posedge i_core_clk);
		#1;
	endtask : pins
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (4000) @(posedge i_core_clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		i_nrst = 1'b0;
		{pin_en, slp1, slp2, use2} = 4'h0;
		rail = '0;
		repeat (10) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		rd_chk(RSD_OFS_REG3_CTRL, RSD_REG3_RESET);
		for (int a = 8'h40; a < 8'h44; a++) rd_chk(8'(a), 8'h00);
		for (int a = 8'h40; a < 8'h43; a++) host.wr(8'(a), 8'hE4);
		#1;
		chk("fields", {2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2}, disch);
		rd_chk(RSD_OFS_DISCH_THREE, 8'h24);
		for (int c = 0; c < 4; c++) begin
			host.wr(RSD_OFS_DISCH_ONE, {4{2'(c)}});
			rd_chk(RSD_OFS_DISCH_ONE, {4{2'(c)}});
			chk("step down one", 22'(c), 22'(disch.step_down_one));
		end
		host.wr(RSD_OFS_DISCH_ONE, 8'hFF);
		@(posedge i_core_clk);
		rail.step_down_two <= RSD_DISCH_100R;
		host.wr(RSD_OFS_DISCH_ONE, 8'hFF);
		rd_chk(RSD_OFS_DISCH_ONE, 8'hF3);
		@(posedge i_core_clk);
		rail <= '0;
		for (int i = 0; i < 7; i++) begin
			host.set_reg_three(pin_cases[i][7], pin_cases[i][6]);
			pins(pin_cases[i][5:2]);
			chk("sleep and enable", 22'(pin_cases[i][1:0]), 22'({reg_slp, reg_en}));
		end
		host.wr(RSD_OFS_REG3_CTRL, 8'hCD);
		rd_chk(RSD_OFS_REG3_CTRL, 8'h0D);
		print_verdict();
	end
endmodule : testbench
